/* rtl/dnm_device.sv */
// Purpose: frame-blank and line-list nmi generator with status registers
// Assumes: display list feeds one instruction per mode line on dl_take
// Notes:
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module dnm_device (
  input  wire logic       clock,
  input  wire logic       srst,
  dnm_if.dev              link,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  input  wire logic [7:0] dl_instr,
  output      logic       dl_take,
  input  wire logic       reset_button
);

  // ------------------------------------------------------------
  // cpu cycle divider and scan position
  // ------------------------------------------------------------
  logic [6:0] div_q;
  logic       tick;
  logic [6:0] hpos_q;
  logic [8:0] vpos_q;
  logic       line_end;

  assign tick     = (div_q == 7'(dnm_pkg::CLKS_PER_CYC - 1));
  assign line_end = tick && (hpos_q == dnm_pkg::CYC_LAST);

  always_ff @(posedge clock) begin
    if (srst || tick) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hpos_q <= 7'h00;
      vpos_q <= 9'h000;
    end else if (line_end) begin
      hpos_q <= 7'h00;
      vpos_q <= (vpos_q == dnm_pkg::LINE_LAST) ? 9'h000 : vpos_q + 9'h001;
    end else if (tick) begin
      hpos_q <= hpos_q + 7'h01;
    end
  end

  assign link.cyc_tick = tick;
  assign link.cyc_pos  = hpos_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] en_q;
  logic [7:0] st_q;
  logic [3:0] vertical_fine_scroll_q;
  logic       wr_en;
  logic       wr_clr;

  assign wr_en  = reg_wr && (reg_addr == dnm_pkg::REG_ENABLE);
  assign wr_clr = reg_wr && (reg_addr == dnm_pkg::REG_CLEAR);

  always_ff @(posedge clock) begin
    if (srst) begin
      en_q <= dnm_pkg::ENABLE_RST;
    end else if (wr_en) begin
      en_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      vertical_fine_scroll_q <= dnm_pkg::VERTICAL_FINE_SCROLL_RST;
    end else if (reg_wr && (reg_addr == dnm_pkg::REG_VERTICAL_FINE_SCROLL)) begin
      vertical_fine_scroll_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        dnm_pkg::REG_STATUS: reg_rdata <= st_q;
        dnm_pkg::REG_VERTICAL_FINE_SCROLL: reg_rdata <= {4'h0, vertical_fine_scroll_q};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // reset button: two flops, then edge
  // ------------------------------------------------------------
  logic btn_s1_q;
  logic btn_s2_q;
  logic btn_s3_q;
  logic btn_rise;

  always_ff @(posedge clock) begin
    if (srst) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
    end else begin
      btn_s1_q <= reset_button;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
    end
  end

  assign btn_rise = btn_s2_q && !btn_s3_q;

  // ------------------------------------------------------------
  // mode lines and row counter
  // ------------------------------------------------------------
  logic [7:0] ir_q;
  logic       scrl_q;       // scroll bit of the current mode line
  logic       scrl_prev_q;
  logic [3:0] row_q;
  logic       need_ir_q;
  logic       active;
  logic [3:0] norm_last;
  logic       ir_scrl;
  logic [3:0] end_row;
  logic       ends_now;
  logic       wait_vb;

  assign active  = (vpos_q < dnm_pkg::LINE_VBLANK);
  // blank lines use bits 6:4 as a count, never as scroll bit
  assign ir_scrl = (dl_instr[3:0] != 4'h0) && dl_instr[dnm_pkg::BIT_DL_SCRL];

  always_comb begin
    case (ir_q[3:0])
      4'h0:    norm_last = {1'b0, ir_q[6:4]};
      4'h1:    norm_last = 4'h0;
      4'h2:    norm_last = 4'h7;
      4'h3:    norm_last = 4'h9;
      4'h4:    norm_last = 4'h7;
      4'h5:    norm_last = 4'hF;
      4'h6:    norm_last = 4'h7;
      4'h7:    norm_last = 4'hF;
      4'h8:    norm_last = 4'h7;
      4'h9:    norm_last = 4'h3;
      4'hA:    norm_last = 4'h3;
      4'hB:    norm_last = 4'h1;
      default: norm_last = 4'h0;
    endcase
  end

  // region end: first unscrolled line after a scrolled one
  assign end_row  = (!scrl_q && scrl_prev_q) ? vertical_fine_scroll_q : norm_last;
  // the interrupt flag sits in bit 7, so match the wait opcode without it
  assign wait_vb  = (ir_q[6:0] == dnm_pkg::DL_WAIT_VB[6:0]);
  assign ends_now = wait_vb ? 1'b0 : (row_q == end_row);

  assign dl_take = active && need_ir_q && tick && (hpos_q == 7'h00);

  always_ff @(posedge clock) begin
    if (srst) begin
      ir_q        <= 8'h00;
      scrl_q      <= 1'b0;
      scrl_prev_q <= 1'b0;
      row_q       <= 4'h0;
      need_ir_q   <= 1'b1;
    end else if (dl_take) begin
      ir_q        <= dl_instr;
      scrl_prev_q <= scrl_q;
      scrl_q      <= ir_scrl;
      row_q       <= (ir_scrl && !scrl_q) ? vertical_fine_scroll_q : 4'h0;
      need_ir_q   <= 1'b0;
    end else if (line_end) begin
      if (vpos_q == dnm_pkg::LINE_LAST) begin
        need_ir_q <= 1'b1;
        scrl_q    <= 1'b0;
      end else if (active && ends_now) begin
        need_ir_q <= 1'b1;
      end else begin
        row_q <= row_q + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt events, line event decided at cycle 5, frame event for all of line 248
  // ------------------------------------------------------------
  logic line_ev_q;
  logic frame_ev;

  // later scroll writes still move the line end via ends_now
  always_ff @(posedge clock) begin
    if (srst || line_end) begin
      line_ev_q <= 1'b0;
    end else if (tick && hpos_q == dnm_pkg::CYC_SCROLL_DL) begin
      line_ev_q <= active && ir_q[dnm_pkg::BIT_DL_IRQ] && !need_ir_q
                   && (ends_now || wait_vb);
    end
  end

  assign frame_ev = (vpos_q == dnm_pkg::LINE_VBLANK);

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  logic at_status;

  assign at_status = tick && (hpos_q == dnm_pkg::CYC_STATUS);

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= dnm_pkg::STATUS_RST;
    end else begin
      // clear first, events after: a same-cycle event wins
      if (wr_clr) begin
        st_q <= 8'h00;
      end
      if (at_status && line_ev_q) begin
        st_q[dnm_pkg::BIT_ST_LINE]  <= 1'b1;
        st_q[dnm_pkg::BIT_ST_FRAME] <= 1'b0;
      end else if (at_status && frame_ev) begin
        st_q[dnm_pkg::BIT_ST_FRAME] <= 1'b1;
        st_q[dnm_pkg::BIT_ST_LINE]  <= 1'b0;
      end
      if (btn_rise) begin
        st_q[dnm_pkg::BIT_ST_RESET] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // nmi line
  // ------------------------------------------------------------
  logic [7:0] en_old_q;   // enable as it stood before cycle 7
  logic       src_line_q;
  logic       late_q;
  logic [1:0] hold_q;
  logic       want;
  logic       want_cut;

  assign want = (line_ev_q && en_q[dnm_pkg::BIT_EN_LINE])
             || (frame_ev && en_q[dnm_pkg::BIT_EN_FRAME]);

  always_ff @(posedge clock) begin
    if (srst) begin
      en_old_q <= dnm_pkg::ENABLE_RST;
    end else if (tick && hpos_q == 7'(dnm_pkg::CYC_STATUS - 7'h01)) begin
      en_old_q <= en_q;
    end
  end

  // status clear strobe plays no part here
  always_ff @(posedge clock) begin
    if (srst) begin
      hold_q     <= 2'h0;
      late_q     <= 1'b0;
      src_line_q <= 1'b0;
    end else if (tick && hpos_q == dnm_pkg::CYC_STATUS && want) begin
      src_line_q <= line_ev_q;
      // enabled only during cycle 7: three cycles later, at 11
      if ((line_ev_q && !en_old_q[dnm_pkg::BIT_EN_LINE])
          || (!line_ev_q && !en_old_q[dnm_pkg::BIT_EN_FRAME])) begin
        late_q <= 1'b1;
      end else begin
        hold_q <= dnm_pkg::NMI_HOLD;
      end
    end else if (want_cut) begin
      // a pulse withdrawn in cycle 8 must not come back in cycle 9
      late_q <= 1'b0;
      hold_q <= 2'h0;
    end else if (tick && late_q
                 && hpos_q == 7'(dnm_pkg::CYC_NMI_LATE - 7'h01)) begin
      late_q <= 1'b0;
      hold_q <= dnm_pkg::NMI_HOLD;
    end else if (tick && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  // a disable written during cycle 8 still withdraws the pulse
  assign want_cut = (hpos_q == dnm_pkg::CYC_NMI)
                 && !(src_line_q ? en_q[dnm_pkg::BIT_EN_LINE]
                                 : en_q[dnm_pkg::BIT_EN_FRAME]);
  assign link.nmi_req = (hold_q != 2'h0) && !want_cut;

endmodule : dnm_device

/* rtl/dnm_pkg.sv */
// Purpose: shared constants of the display nmi generator and its partner
// Assumes: one 100 MHz clock, cpu cycles made by a divider enable
// Notes:   register offsets index a small byte-wide register port
package dnm_pkg;

  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CPU_CYCLE_NS  = 559;
  localparam int CLKS_PER_CYC  = CPU_CYCLE_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // scan timing, in cpu cycles and scan lines
  // ------------------------------------------------------------
  localparam logic [6:0] CYC_LAST      = 7'h71;  // 114 cycles a line
  localparam logic [8:0] LINE_LAST     = 9'h105; // 262 lines a frame
  localparam logic [8:0] LINE_VBLANK   = 9'h0F8; // line 248
  localparam logic [6:0] CYC_SCROLL_DL = 7'h05;
  localparam logic [6:0] CYC_STATUS    = 7'h07;
  localparam logic [6:0] CYC_NMI       = 7'h08;
  localparam logic [6:0] CYC_NMI_LATE  = 7'h0B;
  localparam logic [6:0] CYC_ENTRY_MIN = 7'h0A;
  localparam logic [6:0] CYC_IRQ_BLIND = 7'h04;
  localparam logic [6:0] CYC_COOP_LO   = 7'h05;
  localparam logic [6:0] CYC_COOP_HI   = 7'h09;
  localparam logic [1:0] NMI_HOLD      = 2'h2;   // cycles the line is held
  localparam logic [1:0] NMI_RECOG     = 2'h2;
  localparam logic [2:0] ENTRY_LEN     = 3'h7;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam logic [3:0] REG_ENABLE = 4'h0;  // write only
  localparam logic [3:0] REG_STATUS = 4'h1;  // read only
  localparam logic [3:0] REG_CLEAR  = 4'h2;  // write strobe
  localparam logic [3:0] REG_VERTICAL_FINE_SCROLL = 4'h3;  // write, reads back

  localparam int BIT_EN_LINE  = 6;
  localparam int BIT_EN_FRAME = 7;
  localparam int BIT_ST_LINE  = 7;
  localparam int BIT_ST_FRAME = 6;
  localparam int BIT_ST_RESET = 5;
  localparam int BIT_DL_IRQ   = 7;
  localparam int BIT_DL_SCRL  = 5;

  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] VERTICAL_FINE_SCROLL_RST = 4'h0;
  localparam logic [7:0] DL_WAIT_VB = 8'h41;

endpackage : dnm_pkg

/* rtl/dnm_if.sv */
// Purpose: link between the nmi generator and the processor core
// Assumes: both ends on the same clock
// Notes:   cyc_tick marks one cpu cycle, cyc_pos its place in the line
`timescale 1ns/10ps
interface dnm_if;
  logic       nmi_req;   // high while the nmi line is pulled
  logic       cyc_tick;
  logic [6:0] cyc_pos;

  modport dev  (output nmi_req, output cyc_tick, output cyc_pos);
  modport core (input  nmi_req, input  cyc_tick, input  cyc_pos);
endinterface : dnm_if

/* rtl/dnm_core.sv */
// Purpose: processor side nmi recognition and entry timing
// Assumes: instruction sequencer reports boundaries and irq starts
// Notes:   only the timing of entry is modelled, not the entry itself
`timescale 1ns/10ps
module dnm_core (
  input  wire logic clock,
  input  wire logic srst,
  dnm_if.core       link,
  input  wire logic instr_done,
  input  wire logic irq_start,
  output      logic entry_start,
  output      logic entry_busy,
  output      logic entry_is_nmi,
  output      logic nmi_lost
);

  // ------------------------------------------------------------
  // recognition
  // ------------------------------------------------------------
  logic       nmi_old_q;
  logic [1:0] recog_q;
  logic       pend_q;
  logic       blind_q;
  logic       coop_q;
  logic [2:0] ent_q;
  logic       rise;
  logic       can_enter;

  assign rise = link.cyc_tick && link.nmi_req && !nmi_old_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      nmi_old_q <= 1'b0;
    end else if (link.cyc_tick) begin
      nmi_old_q <= link.nmi_req;
    end
  end

  // irq taken at cycle 4 spans 4..10 and hides the edge
  always_ff @(posedge clock) begin
    if (srst) begin
      blind_q <= 1'b0;
    end else if (irq_start && link.cyc_pos == dnm_pkg::CYC_IRQ_BLIND) begin
      blind_q <= 1'b1;
    end else if (link.cyc_tick && link.cyc_pos == dnm_pkg::CYC_ENTRY_MIN) begin
      blind_q <= 1'b0;
    end
  end

  assign nmi_lost = rise && blind_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      recog_q <= 2'h0;
    end else if (rise && !blind_q && !coop_q) begin
      // the rising tick is the first of the two cycles; an nmi that
      // takes over an irq entry needs no entry of its own
      recog_q <= dnm_pkg::NMI_RECOG - 2'h1;
    end else if (link.cyc_tick && recog_q != 2'h0) begin
      recog_q <= recog_q - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // entry
  // ------------------------------------------------------------
  assign can_enter = pend_q && instr_done && ent_q == 3'h0
                  && link.cyc_pos >= dnm_pkg::CYC_ENTRY_MIN;

  assign entry_start = can_enter || (irq_start && ent_q == 3'h0);
  assign entry_busy  = (ent_q != 3'h0);

  always_ff @(posedge clock) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (link.cyc_tick && recog_q == 2'h1) begin
      pend_q <= 1'b1;
    end else if (can_enter || (coop_q && rise)) begin
      pend_q <= 1'b0;
    end
  end

  // irq started at 5..9 is taken over by the nmi due at 8
  always_ff @(posedge clock) begin
    if (srst) begin
      coop_q <= 1'b0;
    end else if (irq_start && ent_q == 3'h0) begin
      coop_q <= link.cyc_pos >= dnm_pkg::CYC_COOP_LO
             && link.cyc_pos <= dnm_pkg::CYC_COOP_HI;
    end else if (ent_q == 3'h0) begin
      coop_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ent_q <= 3'h0;
    end else if (entry_start) begin
      ent_q <= dnm_pkg::ENTRY_LEN;
    end else if (link.cyc_tick && ent_q != 3'h0) begin
      ent_q <= ent_q - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      entry_is_nmi <= 1'b0;
    end else if (can_enter || (coop_q && rise)) begin
      entry_is_nmi <= 1'b1;
    end else if (entry_start) begin
      entry_is_nmi <= 1'b0;
    end
  end

endmodule : dnm_core

/* verif/dnm_monitor.sv */
// Purpose: checks the nmi line and the cpu cycle count on the link
// Assumes: one clock, srst synchronous and active high
// Notes:   sits beside the link interface, no bind
`timescale 1ns/10ps
module dnm_monitor (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       nmi_req,
  input wire logic       cyc_tick,
  input wire logic [6:0] cyc_pos
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ----
  // helpers
  // ----
  logic [7:0] gap_q;
  logic       armed_q;
  logic       fired_q;
  logic       nmi_q;

  always_ff @(posedge clock) begin
    gap_q <= (srst || cyc_tick) ? 8'h00 : gap_q + 8'h01;
  end
  // first gap after reset has no known start, so it is not judged
  always_ff @(posedge clock) begin
    armed_q <= !srst && (armed_q || cyc_tick);
  end
  always_ff @(posedge clock) begin
    nmi_q <= nmi_req;
  end
  always_ff @(posedge clock) begin
    if (srst || (cyc_tick && cyc_pos == dnm_pkg::CYC_LAST)) begin
      fired_q <= 1'b0;
    end else if (nmi_req && !nmi_q) begin
      fired_q <= 1'b1;
    end
  end

  // ----
  // checks
  // ----
  sequence s_rise;
    $rose(nmi_req);
  endsequence
  sequence s_on_time;
    cyc_pos == dnm_pkg::CYC_NMI || cyc_pos == dnm_pkg::CYC_NMI_LATE;
  endsequence

  chk_tick_gap: assert property (armed_q && cyc_tick |->
    gap_q == 8'h36)
    else $error("cpu cycle tick spacing wrong");
  chk_pos_range: assert property (cyc_pos <= dnm_pkg::CYC_LAST)
    else $error("cycle position beyond line end");
  chk_pos_step: assert property ($past(cyc_tick) && !$past(srst) |->
    cyc_pos == (($past(cyc_pos) == dnm_pkg::CYC_LAST) ? 7'h00
                : $past(cyc_pos) + 7'h01))
    else $error("cycle position did not advance on tick");
  chk_pos_hold: assert property (!$past(cyc_tick) && !$past(srst)
    |-> $stable(cyc_pos))
    else $error("cycle position moved without tick");
  chk_nmi_start: assert property (s_rise |-> s_on_time)
    else $error("nmi raised at wrong cycle");
  chk_nmi_window: assert property (nmi_req |->
    cyc_pos inside {[7'h08:7'h09], [7'h0B:7'h0C]})
    else $error("nmi held outside its window");
  chk_nmi_fall: assert property ($fell(nmi_req) |->
    cyc_pos inside {[7'h08:7'h0D]})
    else $error("nmi released at wrong cycle");
  chk_one_a_line: assert property (s_rise |-> !fired_q)
    else $error("second nmi in one line");
  chk_reset_idle: assert property ($fell(srst) |->
    !nmi_req && cyc_pos == 7'h00)
    else $error("link not idle after reset");
endmodule : dnm_monitor

/* verif/tb.sv */
// Purpose: drives both link ends, scores reads and nmi timing
// Assumes: a line is 6270 clocks, so only early lines are run
// Notes:   line 248 frame events lie beyond this run length
`timescale 1ns/10ps
module tb;
  logic       clock;
  logic       srst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] dl_instr;
  logic       dl_take;
  logic       reset_button;
  logic       instr_done;
  logic       irq_start;
  logic       entry_start;
  logic       entry_busy;
  logic       entry_is_nmi;
  logic       nmi_lost;
  logic       rd_d;
  logic       nmi_d;
  logic       lost_seen;
  logic [6:0] ent_pos;
  logic [7:0] busy_n;
  logic [3:0] scrl;
  logic [7:0] rq[$];
  logic [6:0] nq[$];
  int         err_count;
  int         tests_run;

  dnm_if dnm_if_i ();
  dnm_device dnm_device_i (.clock(clock), .srst(srst), .link(dnm_if_i),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dl_instr(dl_instr),
    .dl_take(dl_take), .reset_button(reset_button));
  dnm_core dnm_core_i (.clock(clock), .srst(srst), .link(dnm_if_i),
    .instr_done(instr_done), .irq_start(irq_start),
    .entry_start(entry_start), .entry_busy(entry_busy),
    .entry_is_nmi(entry_is_nmi), .nmi_lost(nmi_lost));
  dnm_monitor dnm_monitor_i (.clock(clock), .srst(srst),
    .nmi_req(dnm_if_i.nmi_req), .cyc_tick(dnm_if_i.cyc_tick),
    .cyc_pos(dnm_if_i.cyc_pos));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ----
  // scoring
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (err_count == 0 && tests_run > 0 && nq.size() == 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    rd_d  <= reg_rd;
    nmi_d <= dnm_if_i.nmi_req;
    if (rd_d === 1'b1 && rq.size() > 0) chk(reg_rdata, rq.pop_front());
    if (dl_take === 1'b1) chk({1'b0, dnm_if_i.cyc_pos}, 8'h00);
    if (dnm_if_i.nmi_req === 1'b1 && nmi_d === 1'b0) begin
      if (nq.size() == 0) chk({1'b0, dnm_if_i.cyc_pos}, 8'hFF);
      else chk({1'b0, dnm_if_i.cyc_pos}, {1'b0, nq.pop_front()});
    end
    if (dnm_if_i.cyc_tick === 1'b1 && dnm_if_i.cyc_pos == dnm_pkg::CYC_LAST)
    begin
      ent_pos   <= 7'h00;
      busy_n    <= 8'h00;
      lost_seen <= 1'b0;
    end else begin
      if (entry_start === 1'b1) ent_pos <= dnm_if_i.cyc_pos;
      if (entry_busy === 1'b1 && dnm_if_i.cyc_tick === 1'b1) begin
        busy_n <= busy_n + 8'h01;
      end
      if (nmi_lost === 1'b1) lost_seen <= 1'b1;
    end
  end

  // ----
  // drivers
  // ----
  task automatic at_cyc(input logic [6:0] p);
    int n;
    n = 0;
    @(posedge clock);
    while (dnm_if_i.cyc_pos !== p) begin
      n++;
      if (n > 7000) begin
        err_count++;
        conclude();
      end
      @(posedge clock);
    end
  endtask : at_cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask : rd

  task automatic next_line(input logic [7:0] ins, input logic [6:0] due);
    at_cyc(dnm_pkg::CYC_LAST);
    dl_instr <= ins;
    at_cyc(7'h00);
    if (due != 7'h00) nq.push_back(due);
  endtask : next_line

  // ----
  // scenarios
  // ----
  initial begin
    srst = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; dl_instr = 8'h80; reset_button = 1'b0;
    instr_done = 1'b1; irq_start = 1'b0; rd_d = 1'b0; nmi_d = 1'b0;
    lost_seen = 1'b0; ent_pos = 7'h00; busy_n = 8'h00;
    err_count = 0; tests_run = 0;
    scrl = 4'($urandom(16));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(dnm_pkg::REG_STATUS, 8'h00);
    rd(dnm_pkg::REG_VERTICAL_FINE_SCROLL, 8'h00);
    wr(dnm_pkg::REG_ENABLE, 8'h40);
    nq.push_back(dnm_pkg::CYC_NMI);
    at_cyc(7'h06);
    rd(dnm_pkg::REG_STATUS, 8'h00);
    at_cyc(7'h14);
    rd(dnm_pkg::REG_STATUS, 8'h80);
    rd(dnm_pkg::REG_ENABLE, 8'h00);
    rd(4'h4 + 4'($urandom_range(11)), 8'h00);
    at_cyc(7'h28);
    chk({1'b0, ent_pos}, 8'h0A);
    chk(busy_n, 8'h07);
    wr(dnm_pkg::REG_CLEAR, 8'($urandom()));
    rd(dnm_pkg::REG_STATUS, 8'h00);
    wr(dnm_pkg::REG_VERTICAL_FINE_SCROLL, {4'h0, scrl});
    rd(dnm_pkg::REG_VERTICAL_FINE_SCROLL, {4'h0, scrl});
    // enable arriving in cycle 8 is too late for this line
    next_line(8'h80, 7'h00);
    wr(dnm_pkg::REG_ENABLE, 8'h00);
    at_cyc(7'h08);
    wr(dnm_pkg::REG_ENABLE, 8'h40);
    at_cyc(7'h14);
    rd(dnm_pkg::REG_STATUS, 8'h80);
    next_line(8'h80, dnm_pkg::CYC_NMI);
    at_cyc(7'h08);
    wr(dnm_pkg::REG_ENABLE, 8'h00);
    at_cyc(7'h09);
    chk({7'h00, dnm_if_i.nmi_req}, 8'h00);
    next_line(8'h80, 7'h00);
    instr_done <= 1'b0;
    at_cyc(7'h07);
    wr(dnm_pkg::REG_ENABLE, 8'h40);
    nq.push_back(dnm_pkg::CYC_NMI_LATE);
    at_cyc(7'h0F);
    instr_done <= 1'b1;
    at_cyc(7'h28);
    chk({1'b0, ent_pos}, 8'h0F);
    next_line(8'h80, dnm_pkg::CYC_NMI);
    reset_button <= 1'b1;
    repeat (4) @(posedge clock);
    reset_button <= 1'b0;
    at_cyc(7'h14);
    rd(dnm_pkg::REG_STATUS, 8'hA0);
    // clear lands after the rise: line stays pulled
    next_line(8'h80, dnm_pkg::CYC_NMI);
    rd(dnm_pkg::REG_STATUS, 8'hA0);
    at_cyc(7'h08);
    wr(dnm_pkg::REG_CLEAR, 8'($urandom()));
    at_cyc(7'h09);
    chk({7'h00, dnm_if_i.nmi_req}, 8'h01);
    rd(dnm_pkg::REG_STATUS, 8'h00);
    next_line(8'h80, dnm_pkg::CYC_NMI);
    at_cyc(7'h04);
    irq_start <= 1'b1;
    @(posedge clock);
    irq_start <= 1'b0;
    at_cyc(7'h28);
    chk({7'h00, lost_seen}, 8'h01);
    rd(dnm_pkg::REG_STATUS, 8'h80);
    next_line(8'h80, dnm_pkg::CYC_NMI);
    at_cyc(7'h06);
    irq_start <= 1'b1;
    @(posedge clock);
    irq_start <= 1'b0;
    at_cyc(7'h28);
    chk({7'h00, entry_is_nmi}, 8'h01);
    chk({7'h00, ent_pos < 7'h0A}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      next_line(dnm_pkg::DL_WAIT_VB | 8'h80, dnm_pkg::CYC_NMI);
    end
    at_cyc(7'h14);
    conclude();
  end
endmodule : tb
